// File: verilog/ccc_pkg.sv
// Package with register map, field layout and shared types of the core configuration block.
package ccc_pkg;
  localparam int unsigned ADR_W = 12;
  localparam logic [11:0] CFG_OFS    = 12'h0D14;
  localparam logic [11:0] STATUS_OFS = 12'h0D40;
  localparam logic [11:0] MASK_OFS   = 12'h0D44;

  localparam int unsigned BIT_STACK_ALIGN = 9;
  localparam int unsigned BIT_BUS_IGNORE  = 8;
  localparam int unsigned BIT_DIV_TRAP    = 4;
  localparam int unsigned BIT_UNAL_TRAP   = 3;
  localparam int unsigned BIT_UNPRIV_TRIG = 1;
  localparam int unsigned BIT_THREAD_CTL  = 0;
  localparam int unsigned PSR_ALIGN_BIT   = 9;
  localparam logic [31:0] CFG_RESET       = 32'h0000_0200;

  localparam int unsigned EVT_W        = 6;
  localparam int unsigned EVT_DIV      = 0;
  localparam int unsigned EVT_UNAL     = 1;
  localparam int unsigned EVT_BF_IGN   = 2;
  localparam int unsigned EVT_LOCKUP   = 3;
  localparam int unsigned EVT_TRIG_DNY = 4;
  localparam int unsigned EVT_THR_REF  = 5;
  localparam logic [5:0]  EVT_NONE     = 6'h00;

  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b01,
    ST_LOCK = 2'b10
  } ccc_core_e;

  typedef struct packed {
    logic stackAlignSelect;
    logic busFaultIgnore;
    logic divideZeroTrap;
    logic unalignTrap;
    logic unprivTriggerAccess;
    logic threadEntryControl;
  } ccc_cfg_s;

  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
    logic [3:0]       sel;
  } ccc_wr_s;

  localparam ccc_cfg_s CFG_INIT = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

  function automatic logic [31:0] cfgToWord(input ccc_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[BIT_STACK_ALIGN] = c.stackAlignSelect;
    w[BIT_BUS_IGNORE]  = c.busFaultIgnore;
    w[BIT_DIV_TRAP]    = c.divideZeroTrap;
    w[BIT_UNAL_TRAP]   = c.unalignTrap;
    w[BIT_UNPRIV_TRIG] = c.unprivTriggerAccess;
    w[BIT_THREAD_CTL]  = c.threadEntryControl;
    return w;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage : ccc_pkg

// File: verilog/ccc_wb_slave.sv
// Classic Wishbone slave front end with registered acknowledge and read data.
`timescale 1ns/1ps
`default_nettype none
module ccc_wb_slave
  import ccc_pkg::*;
(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Wishbone slave.
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic [3:0]       sel_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Register file side.
  output logic                  wrEn,
  output ccc_wr_s               wrReq,
  input  wire logic [31:0]      rdWord
);
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } ccc_wbst_s;

  ccc_wbst_s st_ff, nxt_st;

  // Writes land on the edge where the master samples ack; a request held past ack writes again every other cycle.
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = cyc_i & stb_i & ~st_ff.ack;
    if (cyc_i & stb_i & ~st_ff.ack & ~we_i) begin
      nxt_st.dat = rdWord;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ack_o     = st_ff.ack;
  assign dat_o     = st_ff.dat;
  assign wrEn      = cyc_i & stb_i & we_i & st_ff.ack;
  assign wrReq     = {adr_i, dat_i, sel_i};
endmodule // ccc_wb_slave
`default_nettype wire

// File: verilog/ccc_irq.sv
// Sticky event status with write-one-to-clear, mask and one level interrupt.
`timescale 1ns/1ps
`default_nettype none
module ccc_irq
  import ccc_pkg::*;
#(
  parameter int unsigned N = EVT_W
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Events and software access.
  input  wire logic [N-1:0] evt,
  input  wire logic         clrEn,
  input  wire logic [N-1:0] clrBits,
  input  wire logic         maskEn,
  input  wire logic [N-1:0] maskBits,
  // State out.
  output logic      [N-1:0] status,
  output logic      [N-1:0] mask,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] mask;
  } ccc_irqst_s;

  ccc_irqst_s st_ff, nxt_st;

  // A new event in the clearing cycle survives the clear.
  always_comb begin
    nxt_st = st_ff;
    if (clrEn) begin
      nxt_st.status = st_ff.status & ~clrBits;
    end
    nxt_st.status = nxt_st.status | evt;
    if (maskEn) begin
      nxt_st.mask = maskBits;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign status = st_ff.status;
  assign mask   = st_ff.mask;
  assign irq    = |(st_ff.status & st_ff.mask);
endmodule // ccc_irq
`default_nettype wire

// File: verilog/ccc_top.sv
// Core configuration and control register with the decisions it steers.
`timescale 1ns/1ps
`default_nettype none
module ccc_top
  import ccc_pkg::*;
(
  // Clock and reset.
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Wishbone slave.
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic [3:0]       sel_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // Interrupt.
  output logic                  irq,
  // Exception entry.
  input  wire logic             excEntry,
  input  wire logic [31:0]      entrySp,
  output logic      [31:0]      entrySpAligned,
  output logic                  entryPsrAlign,
  // Exception return.
  input  wire logic             excReturn,
  input  wire logic [31:0]      retFrameSp,
  input  wire logic             retPsrAlign,
  output logic      [31:0]      retSp,
  // Data bus fault.
  input  wire logic             dataBusFault,
  input  wire logic             faultIsLoadStore,
  input  wire logic             inHardFault,
  input  wire logic             inNmi,
  input  wire logic             inEscalated,
  output logic                  busFaultTaken,
  output logic                  busFaultIgnored,
  output logic                  lockup,
  // Integer divide.
  input  wire logic             divExec,
  input  wire logic             divisorZero,
  output logic                  divTrap,
  output logic                  divQuotZero,
  // Data access alignment.
  input  wire logic             accExec,
  input  wire logic [1:0]       accSize,
  input  wire logic             accMultiple,
  input  wire logic [2:0]       accAddrLow,
  output logic                  usageFault,
  // Software interrupt trigger access.
  input  wire logic             trigAccess,
  input  wire logic             trigPrivileged,
  output logic                  trigGrant,
  output logic                  trigDeny,
  // Thread mode entry.
  input  wire logic             thrReturn,
  input  wire logic             thrOtherActive,
  output logic                  thrEnter,
  output logic                  thrRefuse
);
  typedef struct packed {
    ccc_cfg_s    cfg;
    ccc_core_e   core;
    logic [31:0] entrySp;
    logic        entryBit;
    logic [31:0] retSp;
    logic        bfTaken;
    logic        bfIgnored;
    logic        divTrap;
    logic        divZero;
    logic        usage;
    logic        trigGrant;
    logic        trigDeny;
    logic        thrEnter;
    logic        thrRefuse;
  } ccc_state_s;

  ccc_state_s     st_ff, nxt_st;
  logic           wrEn;
  ccc_wr_s        wrReq;
  logic [31:0]    rdWord;
  logic [31:0]    cfgWord;
  logic [31:0]    cfgNew;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] status;
  logic [EVT_W-1:0] mask;
  logic           highPri;
  logic           misaligned;

  function automatic logic isMisaligned(input logic [1:0] sz, input logic [2:0] a);
    logic r;
    r = 1'b0;
    case (sz)
      SZ_BYTE: r = 1'b0;
      SZ_HALF: r = a[0];
      default: r = |a[1:0];
    endcase
    return r;
  endfunction

  ccc_wb_slave u_bus (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .we_i     (we_i),
    .adr_i    (adr_i),
    .dat_i    (dat_i),
    .sel_i    (sel_i),
    .dat_o    (dat_o),
    .ack_o    (ack_o),
    .wrEn     (wrEn),
    .wrReq    (wrReq),
    .rdWord   (rdWord)
  );

  ccc_irq #(
    .N (EVT_W)
  ) u_irq (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .evt      (evt),
    .clrEn    (wrEn && wrReq.adr == STATUS_OFS && wrReq.sel[0]),
    .clrBits  (wrReq.dat[EVT_W-1:0]),
    .maskEn   (wrEn && wrReq.adr == MASK_OFS && wrReq.sel[0]),
    .maskBits (wrReq.dat[EVT_W-1:0]),
    .status   (status),
    .mask     (mask),
    .irq      (irq)
  );

  assign cfgWord = cfgToWord(st_ff.cfg);
  assign cfgNew  = byteMerge(cfgWord, wrReq.dat, wrReq.sel);

  // Unmapped addresses read zero and swallow writes.
  always_comb begin
    case (adr_i)
      CFG_OFS:    rdWord = cfgWord;
      STATUS_OFS: rdWord = {{(32-EVT_W){1'b0}}, status};
      MASK_OFS:   rdWord = {{(32-EVT_W){1'b0}}, mask};
      default:    rdWord = 32'h0000_0000;
    endcase
  end

  // Only the three handler kinds at priority -1 or -2 are covered by the ignore bit.
  assign highPri    = inHardFault | inNmi | inEscalated;
  assign misaligned = isMisaligned(accSize, accAddrLow);

  always_comb begin
    nxt_st = st_ff;
    if (wrEn && wrReq.adr == CFG_OFS) begin
      // Only the six defined bits are stored; the rest are dropped.
      nxt_st.cfg.stackAlignSelect    = cfgNew[BIT_STACK_ALIGN];
      nxt_st.cfg.busFaultIgnore      = cfgNew[BIT_BUS_IGNORE];
      nxt_st.cfg.divideZeroTrap      = cfgNew[BIT_DIV_TRAP];
      nxt_st.cfg.unalignTrap         = cfgNew[BIT_UNAL_TRAP];
      nxt_st.cfg.unprivTriggerAccess = cfgNew[BIT_UNPRIV_TRIG];
      nxt_st.cfg.threadEntryControl  = cfgNew[BIT_THREAD_CTL];
    end
    if (excEntry) begin
      if (st_ff.cfg.stackAlignSelect) begin
        nxt_st.entrySp  = {entrySp[31:3], 3'b000};
        nxt_st.entryBit = entrySp[2];
      end else begin
        nxt_st.entrySp  = {entrySp[31:2], 2'b00};
        nxt_st.entryBit = 1'b0;
      end
    end
    if (excReturn) begin
      nxt_st.retSp = {retFrameSp[31:3], retFrameSp[2] | retPsrAlign, retFrameSp[1:0]};
    end
    nxt_st.bfTaken   = 1'b0;
    nxt_st.bfIgnored = 1'b0;
    // Lock-up holds until reset; nothing in this block releases it.
    case (st_ff.core)
      ST_RUN: begin
        if (dataBusFault) begin
          if (!highPri) begin
            nxt_st.bfTaken = 1'b1;
          end else if (faultIsLoadStore && st_ff.cfg.busFaultIgnore) begin
            nxt_st.bfIgnored = 1'b1;
          end else begin
            nxt_st.core = ST_LOCK;
          end
        end
      end
      ST_LOCK: nxt_st.core = ST_LOCK;
      default: nxt_st.core = ST_LOCK;
    endcase
    nxt_st.divTrap = divExec & divisorZero & st_ff.cfg.divideZeroTrap;
    nxt_st.divZero = divExec & divisorZero & ~st_ff.cfg.divideZeroTrap;
    nxt_st.usage     = accExec & misaligned & (accMultiple | st_ff.cfg.unalignTrap);
    nxt_st.trigGrant = trigAccess & (trigPrivileged | st_ff.cfg.unprivTriggerAccess);
    nxt_st.trigDeny  = trigAccess & ~trigPrivileged & ~st_ff.cfg.unprivTriggerAccess;
    nxt_st.thrEnter  = thrReturn & (~thrOtherActive | st_ff.cfg.threadEntryControl);
    nxt_st.thrRefuse = thrReturn & thrOtherActive & ~st_ff.cfg.threadEntryControl;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff       <= '0;
      st_ff.cfg   <= CFG_INIT;
      st_ff.core  <= ST_RUN;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_comb begin
    evt               = EVT_NONE;
    evt[EVT_DIV]      = st_ff.divTrap;
    evt[EVT_UNAL]     = st_ff.usage;
    evt[EVT_BF_IGN]   = st_ff.bfIgnored;
    evt[EVT_LOCKUP]   = (st_ff.core == ST_LOCK);
    evt[EVT_TRIG_DNY] = st_ff.trigDeny;
    evt[EVT_THR_REF]  = st_ff.thrRefuse;
  end

  assign entrySpAligned  = st_ff.entrySp;
  assign entryPsrAlign   = st_ff.entryBit;
  assign retSp           = st_ff.retSp;
  assign busFaultTaken   = st_ff.bfTaken;
  assign busFaultIgnored = st_ff.bfIgnored;
  assign lockup          = (st_ff.core == ST_LOCK);
  assign divTrap         = st_ff.divTrap;
  assign divQuotZero     = st_ff.divZero;
  assign usageFault      = st_ff.usage;
  assign trigGrant       = st_ff.trigGrant;
  assign trigDeny        = st_ff.trigDeny;
  assign thrEnter        = st_ff.thrEnter;
  assign thrRefuse       = st_ff.thrRefuse;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_hp_ls_fault;
    dataBusFault && highPri && faultIsLoadStore && !lockup;
  endsequence

  sequence s_cfg_read;
    cyc_i && stb_i && !we_i && !ack_o && adr_i == CFG_OFS;
  endsequence

  a_entry_align: assert property (excEntry |=>
    (entrySpAligned[1:0] == 2'b00) && ($past(st_ff.cfg.stackAlignSelect) ->
    entrySpAligned[2] == 1'b0)) else $error("entry stack not aligned");
  a_psr_bit: assert property (excEntry |=>
    entryPsrAlign == ($past(st_ff.cfg.stackAlignSelect) && $past(entrySp[2])))
    else $error("stacked alignment bit wrong");
  a_ret_restore: assert property (excReturn && retPsrAlign |=> retSp[2])
    else $error("return alignment not restored");
  a_bf_ignore: assert property (s_hp_ls_fault ##0 st_ff.cfg.busFaultIgnore
    |=> busFaultIgnored && !lockup && !busFaultTaken) else $error("bus fault not ignored");
  a_bf_lock: assert property (s_hp_ls_fault ##0 !st_ff.cfg.busFaultIgnore
    |=> lockup [*3]) else $error("no lock-up on fault");
  a_bf_scope: assert property (dataBusFault && !highPri && !lockup
    |=> busFaultTaken && !busFaultIgnored) else $error("ignore outside scope");
  a_div_trap: assert property (divExec && divisorZero && st_ff.cfg.divideZeroTrap
    |=> divTrap && !divQuotZero) else $error("divide trap missing");
  a_div_zero: assert property (divExec && divisorZero && !st_ff.cfg.divideZeroTrap
    |=> divQuotZero && !divTrap) else $error("divide zero quotient missing");
  a_multi_fault: assert property (accExec && accMultiple && accAddrLow[1:0] != 2'b00
    && accSize != SZ_BYTE |=> usageFault) else $error("multiple access not faulted");
  a_unal_trap: assert property (accExec && accSize == SZ_HALF && accAddrLow[0]
    && st_ff.cfg.unalignTrap |=> usageFault) else $error("unaligned trap missing");
  a_unal_pass: assert property (accExec && !accMultiple && !st_ff.cfg.unalignTrap
    |=> !usageFault) else $error("unaligned access trapped");
  a_trig_gate: assert property (trigAccess && !trigPrivileged
    |=> trigGrant == $past(st_ff.cfg.unprivTriggerAccess) && trigDeny != trigGrant)
    else $error("trigger gate wrong");
  a_thr_base: assert property (thrReturn && thrOtherActive && !st_ff.cfg.threadEntryControl
    |=> thrRefuse && !thrEnter) else $error("thread entry not refused");
  a_thr_any: assert property (thrReturn && st_ff.cfg.threadEntryControl
    |=> thrEnter) else $error("thread entry refused");
  a_rsvd_zero: assert property (s_cfg_read |=>
    ack_o && (dat_o & 32'hFFFF_FCE4) == 32'h0000_0000) else $error("reserved bits not zero");
  // Lock-up one cycle old has already reached the status bit, so a mask write cannot race it.
  a_irq_level: assert property (lockup && $past(lockup) && mask[EVT_LOCKUP] |-> irq)
    else $error("interrupt not raised");
endmodule // ccc_top
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking testbench for the core configuration and control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ccc_pkg::*;
  logic             core_clk = 1'b0;
  logic             rst_n = 1'b0;
  logic             cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [31:0]      dat_i = '0, entrySp = '0, retFrameSp = '0;
  logic [3:0]       sel_i = '0;
  logic             excEntry = 1'b0, excReturn = 1'b0, retPsrAlign = 1'b0;
  logic             dataBusFault = 1'b0, faultIsLoadStore = 1'b0;
  logic             inHardFault = 1'b0, inNmi = 1'b0, inEscalated = 1'b0;
  logic             divExec = 1'b0, divisorZero = 1'b0, accExec = 1'b0;
  logic [1:0]       accSize = '0;
  logic             accMultiple = 1'b0;
  logic [2:0]       accAddrLow = '0;
  logic             trigAccess = 1'b0, trigPrivileged = 1'b0;
  logic             thrReturn = 1'b0, thrOtherActive = 1'b0;
  logic [31:0]      dat_o, entrySpAligned, retSp;
  logic             ack_o, irq, entryPsrAlign, busFaultTaken, busFaultIgnored, lockup;
  logic             divTrap, divQuotZero, usageFault, trigGrant, trigDeny, thrEnter, thrRefuse;
  int               err_total = 0;
  int               n_tests = 0;
  integer           seed = 32'h3a8e;
  logic [31:0]      cfgM, rd, d, s;
  logic             locked;

  always #2.5 core_clk = ~core_clk;

  ccc_top u_ccc_top (
    .core_clk(core_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o), .irq(irq),
    .excEntry(excEntry), .entrySp(entrySp), .entrySpAligned(entrySpAligned),
    .entryPsrAlign(entryPsrAlign), .excReturn(excReturn), .retFrameSp(retFrameSp),
    .retPsrAlign(retPsrAlign), .retSp(retSp), .dataBusFault(dataBusFault),
    .faultIsLoadStore(faultIsLoadStore), .inHardFault(inHardFault), .inNmi(inNmi),
    .inEscalated(inEscalated), .busFaultTaken(busFaultTaken),
    .busFaultIgnored(busFaultIgnored), .lockup(lockup), .divExec(divExec),
    .divisorZero(divisorZero), .divTrap(divTrap), .divQuotZero(divQuotZero),
    .accExec(accExec), .accSize(accSize), .accMultiple(accMultiple),
    .accAddrLow(accAddrLow), .usageFault(usageFault), .trigAccess(trigAccess),
    .trigPrivileged(trigPrivileged), .trigGrant(trigGrant), .trigDeny(trigDeny),
    .thrReturn(thrReturn), .thrOtherActive(thrOtherActive), .thrEnter(thrEnter),
    .thrRefuse(thrRefuse)
  );

  task automatic test_done();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Only the implemented fields survive a write; lanes not enabled keep their old bytes.
  function automatic logic [31:0] mergeCfg(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] sl);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (sl[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r & 32'h0000_031B;
  endfunction

  task automatic wbXfer(input logic w, input logic [11:0] a, input logic [31:0] dv,
                        input logic [3:0] sl, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= dv;
    sel_i <= sl;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic doReset(input int n);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    rst_n <= 1'b1;
    cfgM = 32'h0000_0200;
    locked = 1'b0;
  endtask

  // One word of random bits drives every core-side group in the same cycle.
  task automatic corePulse(input logic [31:0] r, input logic [31:0] sp, input logic [31:0] fsp);
    logic hp, ign, mis;
    @(posedge core_clk);
    {dataBusFault, retPsrAlign, excReturn, excEntry} <= r[3:0];
    {inEscalated, inNmi, inHardFault, faultIsLoadStore} <= r[7:4];
    {accExec, divisorZero, divExec} <= r[10:8];
    accSize <= r[12:11];
    accMultiple <= r[13] & r[12];
    accAddrLow <= r[16:14];
    {thrOtherActive, thrReturn, trigPrivileged, trigAccess} <= r[20:17];
    entrySp <= sp;
    retFrameSp <= fsp;
    @(posedge core_clk);
    {excEntry, excReturn, dataBusFault, divExec, accExec, trigAccess, thrReturn} <= 7'h00;
    #1;
    if (r[0]) begin
      chk32(entrySpAligned, cfgM[9] ? {sp[31:3], 3'b000} : {sp[31:2], 2'b00});
      chk1(entryPsrAlign, cfgM[9] & sp[2]);
    end
    if (r[1]) begin
      chk32(retSp, fsp | {29'h0, r[2], 2'b00});
    end
    hp = r[5] | r[6] | r[7];
    ign = hp & r[4] & cfgM[8];
    chk1(busFaultIgnored, r[3] & !locked & ign);
    chk1(busFaultTaken, r[3] & !locked & !hp);
    if (r[3] & hp & !ign) begin
      locked = 1'b1;
    end
    chk1(lockup, locked);
    chk1(divTrap, r[8] & r[9] & cfgM[4]);
    chk1(divQuotZero, r[8] & r[9] & !cfgM[4]);
    mis = r[12] ? (r[15:14] != 2'b00) : (r[11] & r[14]);
    chk1(usageFault, r[10] & mis & (cfgM[3] | (r[13] & r[12])));
    chk1(trigGrant, r[17] & (r[18] | cfgM[1]));
    chk1(trigDeny, r[17] & !r[18] & !cfgM[1]);
    chk1(thrEnter, r[19] & (!r[20] | cfgM[0]));
    chk1(thrRefuse, r[19] & r[20] & !cfgM[0]);
  endtask

  initial begin
    doReset(20);
    wbXfer(1'b0, CFG_OFS, 32'h0000_0000, 4'hF, rd);
    chk32(rd, 32'h0000_0200);
    wbXfer(1'b0, STATUS_OFS, 32'h0000_0000, 4'hF, rd);
    chk32(rd, 32'h0000_0000);
    wbXfer(1'b1, CFG_OFS, 32'hFFFF_FFFF, 4'hF, rd);
    wbXfer(1'b0, CFG_OFS, 32'h0000_0000, 4'hF, rd);
    chk32(rd, 32'h0000_031B);
    wbXfer(1'b1, 12'hFFC, 32'h0000_0000, 4'hF, rd);
    wbXfer(1'b0, 12'hFFC, 32'h0000_0000, 4'hF, rd);
    chk32(rd, 32'h0000_0000);
    // Divide trap raises status, masked first, then unmasked, then cleared.
    wbXfer(1'b1, CFG_OFS, 32'h0000_0210, 4'hF, rd);
    cfgM = 32'h0000_0210;
    corePulse(32'h0000_0300, 32'h0000_0000, 32'h0000_0000);
    wbXfer(1'b0, STATUS_OFS, 32'h0000_0000, 4'hF, rd);
    chk32(rd, 32'h0000_0001);
    chk1(irq, 1'b0);
    wbXfer(1'b1, MASK_OFS, 32'h0000_0001, 4'hF, rd);
    #1;
    chk1(irq, 1'b1);
    wbXfer(1'b1, STATUS_OFS, 32'h0000_0001, 4'hF, rd);
    #1;
    chk1(irq, 1'b0);
    // Only the lock-up event stays unmasked, so the interrupt level is exercised by faults.
    wbXfer(1'b1, MASK_OFS, 32'h0000_0008, 4'hF, rd);
    for (int i = 0; i < 400; i++) begin
      if (i % 50 == 49) begin
        doReset(3);
        wbXfer(1'b0, CFG_OFS, 32'h0000_0000, 4'hF, rd);
        chk32(rd, 32'h0000_0200);
        chk1(lockup, 1'b0);
        wbXfer(1'b1, MASK_OFS, 32'h0000_0008, 4'hF, rd);
      end
      d = $random(seed);
      s = $random(seed);
      if (s[31:30] == 2'b00) begin
        wbXfer(1'b1, CFG_OFS, d, s[3:0], rd);
        cfgM = mergeCfg(cfgM, d, s[3:0]);
        wbXfer(1'b0, CFG_OFS, 32'h0000_0000, 4'hF, rd);
        chk32(rd, cfgM);
      end
      // Bus faults are kept rare so that lockup does not hide the later cases.
      d[3] = d[3] & s[8] & s[9];
      corePulse(d, $random(seed), $random(seed));
    end
    test_done();
  end

  initial begin
    #200000;
    err_total++;
    test_done();
  end
endmodule // tb_top
`default_nettype wire
